// ### verilog/scp_pkg.sv
/*
  constants for the system clock prescaler: register indices, byte
  addresses, field positions, reset values and timing counts.
  assumes a 32-bit apb with one aligned word per register.
*/
package scp_pkg;
  // printed offsets are not word aligned, so they are indices
  localparam logic [9:0] CTRL_IDX = 10'h061;
  localparam logic [9:0] TRIM_IDX = 10'h066;
  localparam logic [9:0] TSTAT_IDX = 10'h06e;
  localparam logic [9:0] STAT_IDX = 10'h070;
  localparam logic [11:0] CTRL_ADDR = {CTRL_IDX, 2'h0};
  localparam logic [11:0] TRIM_ADDR = {TRIM_IDX, 2'h0};
  localparam logic [11:0] TSTAT_ADDR = {TSTAT_IDX, 2'h0};
  localparam logic [11:0] STAT_ADDR = {STAT_IDX, 2'h0};

  localparam int UNLOCK_BIT = 7;
  localparam logic [7:0] UNLOCK_WORD = 8'h80;
  localparam int EXT_CLK_BIT = 0;
  localparam int TOSC_REQ_BIT = 1;

  localparam logic [3:0] CODE_DIV1 = 4'h0;
  localparam logic [3:0] CODE_DIV8 = 4'h3;
  localparam logic [3:0] CODE_MAX = 4'h8;
  localparam logic [7:0] TRIM_RST = 8'h00;

  // unlock window, in master clock cycles
  localparam int UNLOCK_CYCLES = 4;
  localparam logic [1:0] UNLOCK_LAST = 2'(UNLOCK_CYCLES - 1);
endpackage

// ### verilog/scp_prescaler.sv
/*
  system clock prescaler with protected divider change, rc oscillator
  trim register, clock output buffer and timer oscillator selection.
  assumes mclk_i is the undivided source clock, fuses and the
  calibration byte are static, and an apb master on the same clock.
*/
// Added by the designer: the APB interface to the registers.
// How it works
// - timer oscillator enabled only while the rc oscillator is the source.
// - external-clock bit makes the timer pin take an external clock while the timer oscillator is enabled.
// - clock-output fuse drives system clock on the pin, also during reset.
// - the pin carries the divided clock, or the source clock itself at code 0000.
// - the one enable divides cpu, flash, io and adc domains together.
// - no glitch and no faster intermediate period on a division change.
// - new division starts at the end of an old period.
// - ripple count runs on the source clock and is never readable.
// - unlock sets only on a write whose other bits are all zero.
// - unlock clears four cycles after set or on a code write.
// - rewriting unlock in the window neither restarts nor clears it.
// - reset loads code 0000, or 0011 when the divide-by-eight fuse is set.
// - any legal code is accepted through the sequence after reset.
// - code n divides by two to the n, up to 256 at code 1000.
// - each reset loads the factory calibration byte into the trim register.
// - top trim bit picks the low or high range.
// - lower seven trim bits tune within the selected range.
`timescale 1ns/10ps
module scp_prescaler (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic div8_default_fuse_i,
  input wire logic clock_output_fuse_i,
  input wire logic rc_osc_selected_i,
  input wire logic [7:0] calib_byte_i,
  output logic sys_clk_en_o,
  output logic clock_output_pin_o,
  output logic clock_output_oe_o,
  output logic trim_range_select_o,
  output logic [6:0] trim_fine_o,
  output logic timer_osc_enable_o,
  output logic timer_osc_input_pin_ext_o
);

  logic init_q;
  logic unlock_q;
  logic [1:0] win_q;
  logic [3:0] act_q;
  logic [3:0] pend_q;
  logic pend_v_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic div_clk_q;
  logic div_clk_d;
  logic [7:0] act_mask;
  logic [7:0] next_mask;
  logic tick;
  logic [7:0] trim_q;
  logic ext_clk_q;
  logic tosc_req_q;
  logic [2:0] rc_sync_q;
  logic rc_sel_q;
  logic [31:0] prdata_q;
  logic wr_acc;
  logic ctrl_wr;
  logic unlock_wr;
  logic code_wr;
  logic mapped;

  // zero-wait slave
  assign pready_o = 1'b1;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign ctrl_wr = wr_acc && (paddr_i == scp_pkg::CTRL_ADDR);
  assign unlock_wr = ctrl_wr && (pwdata_i[7:0] == scp_pkg::UNLOCK_WORD);
  assign code_wr = ctrl_wr && !pwdata_i[scp_pkg::UNLOCK_BIT];

  always_comb
  begin
    if (paddr_i == scp_pkg::CTRL_ADDR)
      mapped = 1'b1;
    else if (paddr_i == scp_pkg::TRIM_ADDR)
      mapped = 1'b1;
    else if (paddr_i == scp_pkg::TSTAT_ADDR)
      mapped = 1'b1;
    else if (paddr_i == scp_pkg::STAT_ADDR)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  assign pslverr_o = psel_i && penable_i && !mapped;

  // read data captured in the setup cycle
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prdata_q <= 32'h0;
    else if (psel_i && !penable_i)
    begin
      if (paddr_i == scp_pkg::CTRL_ADDR)
        prdata_q <= {24'h0, unlock_q, 3'h0, act_q};
      else if (paddr_i == scp_pkg::TRIM_ADDR)
        prdata_q <= {24'h0, trim_q};
      else if (paddr_i == scp_pkg::TSTAT_ADDR)
        prdata_q <= {30'h0, tosc_req_q, ext_clk_q};
      else if (paddr_i == scp_pkg::STAT_ADDR)
        prdata_q <= {24'h0, pend_v_q, timer_osc_enable_o, rc_sel_q, 1'b0, pend_q};
      else
        prdata_q <= 32'h0;
    end
  end

  assign prdata_o = prdata_q;

  // straps are caught at the first edge after release
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      init_q <= 1'b0;
    else
      init_q <= 1'b1;
  end

  // unlock window; a rewrite inside it changes nothing
  // expiry beats a late rewrite, so the window can never stretch
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      unlock_q <= 1'b0;
      win_q <= 2'h0;
    end
    else if (unlock_q)
    begin
      if (code_wr || win_q == scp_pkg::UNLOCK_LAST)
        unlock_q <= 1'b0;
      win_q <= win_q + 2'h1;
    end
    else if (unlock_wr)
    begin
      unlock_q <= 1'b1;
      win_q <= 2'h0;
    end
  end

  // accepted code waits for the end of the running period
  // a code landing on a boundary waits one whole old period, never a cut one
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pend_q <= scp_pkg::CODE_DIV1;
      pend_v_q <= 1'b0;
    end
    else if (unlock_q && code_wr && pwdata_i[3:0] <= scp_pkg::CODE_MAX)
    begin
      pend_q <= pwdata_i[3:0];
      pend_v_q <= 1'b1;
    end
    else if (tick)
      pend_v_q <= 1'b0;
  end

  // reserved codes above 1000 are dropped
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      act_q <= scp_pkg::CODE_DIV1;
    else if (!init_q)
      act_q <= div8_default_fuse_i ? scp_pkg::CODE_DIV8 : scp_pkg::CODE_DIV1;
    else if (tick && pend_v_q)
      act_q <= pend_q;
  end

  assign act_mask = 8'((9'h1 << act_q) - 9'h1);
  assign next_mask = (tick && pend_v_q) ? 8'((9'h1 << pend_q) - 9'h1) : act_mask;
  assign tick = (cnt_q == act_mask);

  // count restarts at every boundary, so a switch never cuts a period short
  always_comb
  begin
    cnt_d = tick ? 8'h0 : 8'(cnt_q + 8'h1);
    div_clk_d = (cnt_d <= {1'b0, next_mask[7:1]});
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= 8'h0;
      div_clk_q <= 1'b1;
    end
    else if (!init_q)
    begin
      cnt_q <= 8'h0;
      div_clk_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      div_clk_q <= div_clk_d;
    end
  end

  // one enable feeds every synchronous domain
  assign sys_clk_en_o = tick;

  // divide by one passes the source clock through, also under reset
  // both mux inputs step with a rising source edge at a period boundary
  assign clock_output_pin_o = (act_q == scp_pkg::CODE_DIV1) ? mclk_i : div_clk_q;
  assign clock_output_oe_o = clock_output_fuse_i;

  // trim register
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      trim_q <= scp_pkg::TRIM_RST;
    else if (!init_q)
      trim_q <= calib_byte_i;
    else if (wr_acc && paddr_i == scp_pkg::TRIM_ADDR)
      trim_q <= pwdata_i[7:0];
  end

  assign trim_range_select_o = trim_q[7];
  assign trim_fine_o = trim_q[6:0];

  // timer oscillator control
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ext_clk_q <= 1'b0;
      tosc_req_q <= 1'b0;
    end
    else if (wr_acc && paddr_i == scp_pkg::TSTAT_ADDR)
    begin
      ext_clk_q <= pwdata_i[scp_pkg::EXT_CLK_BIT];
      tosc_req_q <= pwdata_i[scp_pkg::TOSC_REQ_BIT];
    end
  end

  // source select arrives from the fuse block, filtered before use
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rc_sync_q <= 3'h0;
      rc_sel_q <= 1'b0;
    end
    else
    begin
      rc_sync_q <= {rc_sync_q[1:0], rc_osc_selected_i};
      if (rc_sync_q[1] == rc_sync_q[2])
        rc_sel_q <= rc_sync_q[2];
    end
  end

  // crystal pins are shared, so the rc source is a must
  assign timer_osc_enable_o = tosc_req_q && rc_sel_q;
  assign timer_osc_input_pin_ext_o = timer_osc_enable_o && ext_clk_q;

  // checking helpers
  logic [7:0] gap_q;
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      gap_q <= 8'h0;
    else if (!init_q || tick)
      gap_q <= 8'h0;
    else
      gap_q <= 8'(gap_q + 8'h1);
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_unlock_req;
    unlock_wr && !unlock_q;
  endsequence

  sequence s_window_open;
    $rose(unlock_q);
  endsequence

  sequence s_quiet3;
    (!code_wr) [*3];
  endsequence

  sequence s_code_reject;
    unlock_q && code_wr && pwdata_i[3:0] > scp_pkg::CODE_MAX;
  endsequence

  unlock_set_a: assert property (s_unlock_req |=> unlock_q)
    else $error("unlock not set by 0x80 write");

  unlock_other_a: assert property (ctrl_wr && !unlock_q && !unlock_wr |=> !unlock_q)
    else $error("unlock set by non-0x80 write");

  unlock_timeout_a: assert property (s_window_open |-> ##4 !unlock_q)
    else $error("unlock window longer than four cycles");

  rewrite_keep_a: assert property (unlock_q && unlock_wr && win_q != 2'h3 |=> unlock_q)
    else $error("rewrite cleared unlock");

  code_take_a: assert property (unlock_q && code_wr && pwdata_i[3:0] <= 4'h8
    |=> pend_v_q && pend_q == $past(pwdata_i[3:0]))
    else $error("code not taken in window");

  locked_hold_a: assert property (!unlock_q && code_wr && init_q |=> $stable(pend_q))
    else $error("code taken without unlock");

  period_exact_a: assert property (init_q && tick |-> gap_q == act_mask)
    else $error("divided period not the selected factor");

  switch_edge_a: assert property (init_q && $past(init_q) && !$stable(act_q)
    |-> $past(tick) && $past(pend_v_q))
    else $error("division changed mid period");

  div1_tick_a: assert property (init_q && act_q == 4'h0 |-> tick)
    else $error("divide by one lost enables");

  clkout_div_a: assert property (act_q != 4'h0 |-> clock_output_pin_o == div_clk_q)
    else $error("clock pin not divided");

  reset_code_a: assert property ($rose(init_q) |-> act_q == ($past(div8_default_fuse_i) ? 4'h3 : 4'h0))
    else $error("wrong reset division");

  trim_load_a: assert property ($rose(init_q) |-> trim_q == $past(calib_byte_i))
    else $error("trim not loaded at reset");

  tosc_gate_a: assert property (!rc_sel_q |-> !timer_osc_enable_o)
    else $error("timer oscillator on without rc source");

  // window length and closing
  code_close_a: assert property (unlock_q && code_wr |=> !unlock_q)
    else $error("code write left unlock set");

  unlock_span_a: assert property (s_window_open ##0 s_quiet3 |=> unlock_q)
    else $error("unlock window shorter than four cycles");

  code_drop_a: assert property (s_code_reject |=> !unlock_q && $stable(pend_q))
    else $error("reserved code taken");

  // division switch
  pend_apply_a: assert property (init_q && tick && pend_v_q && !(unlock_q && code_wr)
    |=> act_q == $past(pend_q) && !pend_v_q)
    else $error("pending code not applied at boundary");

  locked_act_a: assert property (init_q && !unlock_q && code_wr && !pend_v_q
    |=> $stable(act_q))
    else $error("active code changed without unlock");

  // divided clock shape
  reset_cnt_a: assert property ($rose(init_q) |-> cnt_q == 8'h0 && div_clk_q)
    else $error("divider not restarted after reset");

  div_rise_a: assert property ($rose(div_clk_q) |-> $past(tick))
    else $error("divided clock rose inside a period");

  div_fall_a: assert property ($fell(div_clk_q)
    |-> $past(cnt_q) == $past({1'b0, act_mask[7:1]}))
    else $error("divided clock high phase wrong");

  // register writes after the reset loads
  trim_write_a: assert property (init_q && wr_acc && paddr_i == scp_pkg::TRIM_ADDR
    |=> trim_q == $past(pwdata_i[7:0]))
    else $error("trim write lost");

  tstat_write_a: assert property (wr_acc && paddr_i == scp_pkg::TSTAT_ADDR
    |=> ext_clk_q == $past(pwdata_i[scp_pkg::EXT_CLK_BIT]))
    else $error("external clock bit not written");

endmodule

// ### dv/scp_prescaler_test.sv
/*
  self-checking bench for scp_prescaler: apb access, protected divider
  change, trim, timer oscillator selection, clock output and reset.
  assumes the zero-wait apb slave and reset loads of scp_pkg.
*/
`timescale 1ns/10ps
module scp_prescaler_test;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic div8_fuse, out_fuse, rc_sel, en, pin, oe, rng, tmr_en, tmr_ext;
  logic [7:0] calib;
  logic [6:0] fine;
  int failures, total_checks, prev;

  scp_prescaler dut (.mclk_i(mclk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .div8_default_fuse_i(div8_fuse),
    .clock_output_fuse_i(out_fuse), .rc_osc_selected_i(rc_sel), .calib_byte_i(calib),
    .sys_clk_en_o(en), .clock_output_pin_o(pin), .clock_output_oe_o(oe),
    .trim_range_select_o(rng), .trim_fine_o(fine), .timer_osc_enable_o(tmr_en),
    .timer_osc_input_pin_ext_o(tmr_ext));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // request held until pready is seen high; answer taken at that same edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic got;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    got = 1'b0;
    n = 0;
    while (!got && n < 50)
    begin
      @(posedge mclk);
      got = (pready === 1'b1);
      rd = prdata;
      er = pslverr;
      n++;
    end
    if (!got)
    begin
      failures++;
      report_and_stop();
    end
  endtask

  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    chk("oe_in_reset", {31'h0, out_fuse}, {31'h0, oe});
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  task automatic rd_ctrl(input logic [31:0] exp);
    apb(1'b0, scp_pkg::CTRL_ADDR, 32'h0);
    idle(1);
    chk("ctrl", exp, rd);
  endtask

  // back-to-back writes keep the code write inside the unlock window
  task automatic setdiv(input logic [7:0] code);
    apb(1'b1, scp_pkg::CTRL_ADDR, {24'h0, scp_pkg::UNLOCK_WORD});
    apb(1'b1, scp_pkg::CTRL_ADDR, {24'h0, code});
    idle(1);
  endtask

  // measures the last of three enable intervals; also the shortest seen
  task automatic period(input int exp, input int low);
    int n, seen, gap, last, hi, lasthi, mingap;
    n = 0;
    seen = 0;
    gap = 0;
    last = 0;
    hi = 0;
    lasthi = 0;
    mingap = 1000;
    while (seen < 4 && n < 2000)
    begin
      @(negedge mclk);
      n++;
      gap++;
      if (pin === 1'b1)
        hi++;
      if (en === 1'b1)
      begin
        if (seen > 0 && gap < mingap)
          mingap = gap;
        last = gap;
        lasthi = hi;
        gap = 0;
        hi = 0;
        seen++;
      end
    end
    chk("period", exp, last);
    if (exp > 1)
      chk("pin_high", exp / 2, lasthi);
    chk("no_faster", 1, {31'h0, mingap >= low});
    if (n >= 2000)
    begin
      failures++;
      report_and_stop();
    end
    @(posedge mclk);
  endtask

  task automatic t_reset_vals(input logic [3:0] code);
    rd_ctrl({28'h0, code});
    apb(1'b0, scp_pkg::TRIM_ADDR, 32'h0);
    idle(1);
    chk("trim", {24'h0, calib}, rd);
    chk("trim_out", {24'h0, calib}, {24'h0, rng, fine});
  endtask

  task automatic t_trim();
    apb(1'b1, scp_pkg::TRIM_ADDR, 32'h7f);
    idle(2);
    chk("trim_lo", {24'h0, 8'h7f}, {24'h0, rng, fine});
    apb(1'b1, scp_pkg::TRIM_ADDR, 32'h80);
    apb(1'b0, scp_pkg::TRIM_ADDR, 32'h0);
    idle(1);
    chk("trim_hi", 32'h80, rd);
    chk("trim_hi_out", {24'h0, 8'h80}, {24'h0, rng, fine});
  endtask

  task automatic t_divide();
    prev = 1;
    for (int c = 0; c <= 8; c++)
    begin
      setdiv(8'(c));
      period(1 << c, (prev < (1 << c)) ? prev : (1 << c));
      rd_ctrl(32'(c));
      prev = 1 << c;
    end
    setdiv(8'h09);
    rd_ctrl(32'h8);
  endtask

  task automatic t_guard();
    apb(1'b1, scp_pkg::CTRL_ADDR, 32'h05);
    rd_ctrl(32'h8);
    apb(1'b1, scp_pkg::CTRL_ADDR, 32'h81);
    apb(1'b1, scp_pkg::CTRL_ADDR, 32'h05);
    rd_ctrl(32'h8);
    apb(1'b1, scp_pkg::CTRL_ADDR, 32'h80);
    rd_ctrl(32'h88);
    idle(2);
    rd_ctrl(32'h8);
    apb(1'b1, scp_pkg::CTRL_ADDR, 32'h02);
    rd_ctrl(32'h8);
    apb(1'b1, scp_pkg::CTRL_ADDR, 32'h80);
    apb(1'b1, scp_pkg::CTRL_ADDR, 32'h80);
    rd_ctrl(32'h88);
    rd_ctrl(32'h8);
  endtask

  task automatic t_timer();
    apb(1'b1, scp_pkg::TSTAT_ADDR, 32'h3);
    rc_sel <= 1'b1;
    idle(5);
    chk("tosc_on", 32'h3, {30'h0, tmr_en, tmr_ext});
    rc_sel <= 1'b0;
    idle(5);
    chk("tosc_rc_off", 32'h0, {30'h0, tmr_en, tmr_ext});
    apb(1'b1, scp_pkg::TSTAT_ADDR, 32'h2);
    rc_sel <= 1'b1;
    idle(5);
    chk("tosc_crystal", 32'h2, {30'h0, tmr_en, tmr_ext});
    apb(1'b0, 12'h000, 32'h0);
    idle(1);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_rd", 32'h0, rd);
  endtask

  initial
  begin
    failures = 0;
    total_checks = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    div8_fuse = 1'b0;
    out_fuse = 1'b1;
    rc_sel = 1'b0;
    calib = 8'ha5;
    do_reset();
    t_reset_vals(4'h0);
    t_trim();
    t_divide();
    t_guard();
    t_timer();
    div8_fuse <= 1'b1;
    out_fuse <= 1'b0;
    calib <= 8'h3c;
    do_reset();
    t_reset_vals(4'h3);
    period(8, 8);
    setdiv(8'h00);
    period(1, 1);
    report_and_stop();
  end
endmodule
